// file: rtl/ccp_core.sv
// Purpose: Two capture/compare/PWM channels with the peripheral event flag register
// Assumes: Timers, serial, converter and parallel port live outside and report here
// Notes:   Flags are sticky except live bits 4 and 5, set wins over a software write of zero
//
// Contract
// - Mode zero disables channel, resets its state
// - Capture on falling, rising, 4th, 16th edge
// - Mode 1000 drives output high on match
// - Mode 1001 drives output low on match
// - Mode 1010 flags only, pin unchanged
// - Flags set regardless of enables
// - Channel one flag set on capture, sticky
// - Channel one flag on compare, unused in PWM
// - Bit 1 set on narrow timer period match
// - Bit 0 set on wide timer overflow
// - Bit 5 shows receive buffer full, read-only
// - Bit 4 shows transmit buffer empty, read-only
// - Bit 7 set on parallel port access, sticky
// - Bit 6 set on conversion done, sticky
// - Bit 3 set on sync serial event, sticky
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ccp_core
(
   input  wire logic              CLK,          // Core clock, 20 MHz
   input  wire logic              RSTN,         // Asynchronous reset, active low
   input  wire logic [7:0]        ADDR,         // Register address
   input  wire logic [7:0]        WDATA,        // Write data
   input  wire logic              WR,           // Write strobe
   input  wire logic              RD,           // Read strobe
   output var  logic [7:0]        RDATA,        // Read data, cycle after RD
   input  wire logic [15:0]       WIDE_TIMER,   // Wide timer count
   input  wire logic [7:0]        NARROW_TIMER, // Narrow timer count
   input  wire logic [1:0]        NARROW_FINE,  // Fine bits extending narrow timer
   input  wire ccp_pkg::events_type EVENTS,     // Peripheral event pulses and levels
   input  wire logic [1:0]        CH_PIN,       // Channel capture pins
   output var  logic [1:0]        CH_OUT,       // Channel compare/PWM outputs
   output var  logic              TIMER_RESET,  // Special event timer reset pulse
   output var  logic              CONV_START,   // Special event conversion start pulse
   output var  logic              IRQ           // Level interrupt
);

   typedef struct packed
   {
      ccp_pkg::chan_type [1:0] ch;
      logic [7:0]              flags;
      logic [7:0]              enables;
      logic [7:0]              rdata;
      logic                    tmr_rst;
      logic                    conv;
      logic                    irq;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic [1:0] hit;       // Channel event this cycle
   logic [7:0] flag_view;

   // Live serial bits are never stored; they follow their buffers
   always_comb
   begin
      flag_view = s_r.flags;
      flag_view[ccp_pkg::FLG_RXF] = EVENTS.rx_full;
      flag_view[ccp_pkg::FLG_TXE] = EVENTS.tx_empty;
   end

   // Next-state logic for channels, flags and register port
   always_comb
   begin
      logic [3:0] md;
      logic       rise;
      logic       fall;
      logic [7:0] wmask;
      s_nxt = s_r;
      s_nxt.tmr_rst = 1'b0;
      s_nxt.conv = 1'b0;
      s_nxt.rdata = ccp_pkg::BYTE_ZERO;
      hit = 2'b00;
      md = 4'h0;
      rise = 1'b0;
      fall = 1'b0;
      wmask = ccp_pkg::BYTE_ZERO;
      for (int c = 0; c < 2; c++)
      begin
         md = s_r.ch[c].ctrl[3:0];
         rise = CH_PIN[c] & ~s_r.ch[c].pin_d;
         fall = ~CH_PIN[c] & s_r.ch[c].pin_d;
         s_nxt.ch[c].pin_d = CH_PIN[c];
         if (md[3:2] == ccp_pkg::PWM_TOP)
         begin
            // 10-bit duty, latched at each period start
            if (NARROW_TIMER == 8'h00 && NARROW_FINE == 2'b00)
               s_nxt.ch[c].duty_latch = {s_r.ch[c].duty_hi, s_r.ch[c].ctrl[5:4]};
            s_nxt.ch[c].out = ({NARROW_TIMER, NARROW_FINE} < s_r.ch[c].duty_latch);
         end
         else if (md[3])
         begin
            if (WIDE_TIMER == s_r.ch[c].cmp)
            begin
               hit[c] = 1'b1;
               case (md)
                  ccp_pkg::MODE_CMP_HI: s_nxt.ch[c].out = 1'b1;
                  ccp_pkg::MODE_CMP_LO: s_nxt.ch[c].out = 1'b0;
                  ccp_pkg::MODE_CMP_SW: s_nxt.ch[c].out = s_r.ch[c].out;
                  ccp_pkg::MODE_CMP_SE:
                  begin
                     s_nxt.tmr_rst = 1'b1;
                     if (c == 1)
                        s_nxt.conv = 1'b1;
                  end
                  default: s_nxt.ch[c].out = s_r.ch[c].out;
               endcase
            end
         end
         else if (md[2])
         begin
            // Edge select and prescaler for capture
            case (md)
               ccp_pkg::MODE_CAP_F: hit[c] = fall;
               ccp_pkg::MODE_CAP_R: hit[c] = rise;
               ccp_pkg::MODE_CAP_R4:
                  hit[c] = rise && (s_r.ch[c].presc == ccp_pkg::PRESC_4);
               ccp_pkg::MODE_CAP_R16:
                  hit[c] = rise && (s_r.ch[c].presc == ccp_pkg::PRESC_16);
               default: hit[c] = 1'b0;
            endcase
            if (rise)
               s_nxt.ch[c].presc = (hit[c]) ? 4'h0 : s_r.ch[c].presc + 4'h1;
            if (hit[c])
               s_nxt.ch[c].cap = WIDE_TIMER;
         end
         else if (md == ccp_pkg::MODE_OFF)
         begin
            // Disabled channel holds its output, prescaler, capture and latched duty at reset
            s_nxt.ch[c].out = 1'b0;
            s_nxt.ch[c].presc = 4'h0;
            s_nxt.ch[c].cap = 16'h0000;
            s_nxt.ch[c].duty_latch = 10'h000;
         end
      end

      // Register writes; software may only clear or set stored flag bits
      if (WR)
      begin
         case (ADDR)
            ccp_pkg::ADDR_FLAGS:
            begin
               wmask = ccp_pkg::FLAG_WMASK;
               s_nxt.flags = (WDATA & wmask) | (s_r.flags & ~wmask);
            end
            ccp_pkg::ADDR_ENABLES: s_nxt.enables = WDATA;
            ccp_pkg::ADDR_CTRL1:
            begin
               s_nxt.ch[0].ctrl = WDATA & ccp_pkg::CTRL_WMASK;
               if (WDATA[3:0] != s_r.ch[0].ctrl[3:0])
                  s_nxt.ch[0].presc = 4'h0;  // Mode change restarts prescaler
            end
            ccp_pkg::ADDR_CTRL2:
            begin
               s_nxt.ch[1].ctrl = WDATA & ccp_pkg::CTRL_WMASK;
               if (WDATA[3:0] != s_r.ch[1].ctrl[3:0])
                  s_nxt.ch[1].presc = 4'h0;
            end
            ccp_pkg::ADDR_DUTY1:   s_nxt.ch[0].duty_hi = WDATA;
            ccp_pkg::ADDR_DUTY2:   s_nxt.ch[1].duty_hi = WDATA;
            ccp_pkg::ADDR_CMP1_LO: s_nxt.ch[0].cmp[7:0] = WDATA;
            ccp_pkg::ADDR_CMP1_HI: s_nxt.ch[0].cmp[15:8] = WDATA;
            ccp_pkg::ADDR_CMP2_LO: s_nxt.ch[1].cmp[7:0] = WDATA;
            ccp_pkg::ADDR_CMP2_HI: s_nxt.ch[1].cmp[15:8] = WDATA;
            default: s_nxt.enables = s_r.enables;
         endcase
      end

      // Hardware sets come last so they win over a clearing write
      if (hit[0])
         s_nxt.flags[ccp_pkg::FLG_CH1] = 1'b1;
      if (EVENTS.wide_ovf)
         s_nxt.flags[ccp_pkg::FLG_WIDE] = 1'b1;
      if (EVENTS.period_match)
         s_nxt.flags[ccp_pkg::FLG_PER] = 1'b1;
      if (EVENTS.sync_serial)
         s_nxt.flags[ccp_pkg::FLG_SYNC] = 1'b1;
      if (EVENTS.conv_done)
         s_nxt.flags[ccp_pkg::FLG_CONV] = 1'b1;
      if (EVENTS.par_access)
         s_nxt.flags[ccp_pkg::FLG_PAR] = 1'b1;
      s_nxt.flags[ccp_pkg::FLG_RXF] = 1'b0;
      s_nxt.flags[ccp_pkg::FLG_TXE] = 1'b0;

      // Read mux, data shown one cycle after the strobe
      if (RD)
      begin
         case (ADDR)
            ccp_pkg::ADDR_FLAGS:   s_nxt.rdata = flag_view;
            ccp_pkg::ADDR_ENABLES: s_nxt.rdata = s_r.enables;
            ccp_pkg::ADDR_CTRL1:   s_nxt.rdata = s_r.ch[0].ctrl;
            ccp_pkg::ADDR_CTRL2:   s_nxt.rdata = s_r.ch[1].ctrl;
            ccp_pkg::ADDR_DUTY1:   s_nxt.rdata = s_r.ch[0].duty_hi;
            ccp_pkg::ADDR_DUTY2:   s_nxt.rdata = s_r.ch[1].duty_hi;
            ccp_pkg::ADDR_CMP1_LO: s_nxt.rdata = s_r.ch[0].cmp[7:0];
            ccp_pkg::ADDR_CMP1_HI: s_nxt.rdata = s_r.ch[0].cmp[15:8];
            ccp_pkg::ADDR_CMP2_LO: s_nxt.rdata = s_r.ch[1].cmp[7:0];
            ccp_pkg::ADDR_CMP2_HI: s_nxt.rdata = s_r.ch[1].cmp[15:8];
            ccp_pkg::ADDR_CAP1_LO: s_nxt.rdata = s_r.ch[0].cap[7:0];
            ccp_pkg::ADDR_CAP1_HI: s_nxt.rdata = s_r.ch[0].cap[15:8];
            ccp_pkg::ADDR_CAP2_LO: s_nxt.rdata = s_r.ch[1].cap[7:0];
            ccp_pkg::ADDR_CAP2_HI: s_nxt.rdata = s_r.ch[1].cap[15:8];
            default:               s_nxt.rdata = ccp_pkg::BYTE_ZERO;
         endcase
      end

      // Interrupt from enabled flags; flags themselves ignore enables
      s_nxt.irq = |(s_nxt.flags & s_nxt.enables)
                | (EVENTS.rx_full & s_nxt.enables[ccp_pkg::FLG_RXF])
                | (EVENTS.tx_empty & s_nxt.enables[ccp_pkg::FLG_TXE]);
   end

   // State register
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign RDATA = s_r.rdata;
   assign CH_OUT = {s_r.ch[1].out, s_r.ch[0].out};
   assign TIMER_RESET = s_r.tmr_rst;
   assign CONV_START = s_r.conv;
   assign IRQ = s_r.irq;

   // Checks
   sequence ch0_cmp_hit;
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CMP_HI && WIDE_TIMER == s_r.ch[0].cmp;
   endsequence

   chk_disable_clears: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:0] == 4'h0 |=> !CH_OUT[0]) else $error("disabled channel output high");
   chk_capture_value: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CAP_R && CH_PIN[0] && !s_r.ch[0].pin_d
      |=> s_r.ch[0].cap == $past(WIDE_TIMER)) else $error("capture value wrong");
   chk_cmp_set_high: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_cmp_hit |=> CH_OUT[0] && s_r.flags[ccp_pkg::FLG_CH1]) else $error("compare high missed");
   chk_cmp_set_low: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[1].ctrl[3:0] == ccp_pkg::MODE_CMP_LO && WIDE_TIMER == s_r.ch[1].cmp
      |=> !CH_OUT[1]) else $error("compare low missed");
   chk_soft_pin_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CMP_SW |=> $stable(CH_OUT[0])) else $error("pin moved");
   chk_special_conv: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[1].ctrl[3:0] == ccp_pkg::MODE_CMP_SE && WIDE_TIMER == s_r.ch[1].cmp
      |=> CONV_START && TIMER_RESET ##1 !CONV_START) else $error("special event wrong");
   chk_flag_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.flags[ccp_pkg::FLG_WIDE] && !(WR && ADDR == ccp_pkg::ADDR_FLAGS)
      |=> s_r.flags[ccp_pkg::FLG_WIDE]) else $error("flag lost");
   chk_period_set: assert property (@(posedge CLK) disable iff (!RSTN)
      EVENTS.period_match |=> s_r.flags[ccp_pkg::FLG_PER]) else $error("period flag missed");
   chk_conv_set: assert property (@(posedge CLK) disable iff (!RSTN)
      EVENTS.conv_done |=> s_r.flags[ccp_pkg::FLG_CONV]) else $error("conversion flag missed");
   chk_rx_live: assert property (@(posedge CLK) disable iff (!RSTN)
      RD && ADDR == ccp_pkg::ADDR_FLAGS |=> RDATA[ccp_pkg::FLG_RXF] == $past(EVENTS.rx_full))
      else $error("receive bit wrong");

   // Building blocks for the channel checks below
   sequence ch0_pwm_mode;
      s_r.ch[0].ctrl[3:2] == ccp_pkg::PWM_TOP;
   endsequence

   sequence ch0_below_duty;
      {NARROW_TIMER, NARROW_FINE} < s_r.ch[0].duty_latch;
   endsequence

   sequence ch0_period_start;
      NARROW_TIMER == 8'h00 && NARROW_FINE == 2'b00;
   endsequence

   sequence ch1_special_hit;
      s_r.ch[1].ctrl[3:0] == ccp_pkg::MODE_CMP_SE && WIDE_TIMER == s_r.ch[1].cmp;
   endsequence

   sequence ch0_special_hit;
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CMP_SE && WIDE_TIMER == s_r.ch[0].cmp;
   endsequence

   sequence ch0_rise_capture;
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CAP_R && CH_PIN[0] && !s_r.ch[0].pin_d;
   endsequence

   sequence ch0_soft_hit;
      s_r.ch[0].ctrl[3:0] == ccp_pkg::MODE_CMP_SW && WIDE_TIMER == s_r.ch[0].cmp;
   endsequence

   // A disabled channel must not keep a stale capture or prescale count
   chk_disable_state: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:0] == 4'h0 |=> s_r.ch[0].presc == 4'h0 && s_r.ch[0].cap == 16'h0000)
      else $error("disabled channel state kept");

   // Capture on a rising edge raises the channel one flag
   chk_capture_flag: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_rise_capture |=> s_r.flags[ccp_pkg::FLG_CH1]) else $error("capture flag missed");

   // Software-interrupt compare still flags the match
   chk_soft_flag: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_soft_hit |=> s_r.flags[ccp_pkg::FLG_CH1]) else $error("soft compare flag missed");

   // Special event on channel one pulses the timer reset
   chk_special_reset: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_special_hit |=> TIMER_RESET) else $error("timer reset missed");

   // A conversion start only follows a special-event match on channel two
   chk_special_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
      !(s_r.ch[1].ctrl[3:0] == ccp_pkg::MODE_CMP_SE && WIDE_TIMER == s_r.ch[1].cmp)
      |=> !CONV_START) else $error("stray conversion start");

   // The conversion start is raised by the channel two match
   chk_special_start: assert property (@(posedge CLK) disable iff (!RSTN)
      ch1_special_hit |=> CONV_START) else $error("conversion start missed");

   // PWM output is high while the ten-bit count is below the latched duty
   chk_pwm_high: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_pwm_mode and ch0_below_duty |=> CH_OUT[0]) else $error("pwm output low");

   chk_pwm_low: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:2] == ccp_pkg::PWM_TOP
      && !({NARROW_TIMER, NARROW_FINE} < s_r.ch[0].duty_latch)
      |=> !CH_OUT[0]) else $error("pwm output high");

   // Duty is only taken at period start, so a mid-period write cannot glitch
   chk_pwm_latch: assert property (@(posedge CLK) disable iff (!RSTN)
      ch0_pwm_mode and ch0_period_start
      |=> s_r.ch[0].duty_latch[9:2] == $past(s_r.ch[0].duty_hi)) else $error("duty not latched");

   // In PWM the channel flag is unused: nothing but software may set it
   chk_pwm_no_flag: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.ch[0].ctrl[3:2] == ccp_pkg::PWM_TOP && !s_r.flags[ccp_pkg::FLG_CH1]
      && !(WR && ADDR == ccp_pkg::ADDR_FLAGS)
      |=> !s_r.flags[ccp_pkg::FLG_CH1]) else $error("pwm raised flag");

   // Flags set with every enable off as well
   chk_flag_free: assert property (@(posedge CLK) disable iff (!RSTN)
      EVENTS.wide_ovf |=> s_r.flags[ccp_pkg::FLG_WIDE]) else $error("overflow flag missed");

   // No enables, no interrupt, whatever the flags say
   chk_irq_masked: assert property (@(posedge CLK) disable iff (!RSTN)
      s_r.enables == 8'h00 && !WR |=> !IRQ) else $error("irq while masked");

   chk_tx_live: assert property (@(posedge CLK) disable iff (!RSTN)
      RD && ADDR == ccp_pkg::ADDR_FLAGS |=> RDATA[ccp_pkg::FLG_TXE] == $past(EVENTS.tx_empty))
      else $error("transmit bit wrong");

   chk_par_set: assert property (@(posedge CLK) disable iff (!RSTN)
      EVENTS.par_access |=> s_r.flags[ccp_pkg::FLG_PAR]) else $error("parallel flag missed");

   chk_sync_set: assert property (@(posedge CLK) disable iff (!RSTN)
      EVENTS.sync_serial |=> s_r.flags[ccp_pkg::FLG_SYNC]) else $error("sync flag missed");

endmodule
`default_nettype wire

// file: inc/ccp_pkg.sv
// Purpose: Shared constants and carriers for the two-channel capture/compare/PWM block
// Assumes: 8-bit register port, one 20 MHz core clock
// Notes:   Offsets are byte addresses of the register port
package ccp_pkg;
   localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
   localparam logic [7:0] ADDR_CTRL1   = 8'h17;
   localparam logic [7:0] ADDR_CTRL2   = 8'h1d;
   localparam logic [7:0] ADDR_ENABLES = 8'h8c;
   localparam logic [7:0] ADDR_DUTY1   = 8'h15;
   localparam logic [7:0] ADDR_DUTY2   = 8'h1b;
   localparam logic [7:0] ADDR_CMP1_LO = 8'h13;
   localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
   localparam logic [7:0] ADDR_CMP2_LO = 8'h19;
   localparam logic [7:0] ADDR_CMP2_HI = 8'h1a;
   localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
   localparam logic [7:0] ADDR_CAP1_HI = 8'h11;
   localparam logic [7:0] ADDR_CAP2_LO = 8'h1e;
   localparam logic [7:0] ADDR_CAP2_HI = 8'h1f;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   // Flag bit positions
   localparam int FLG_WIDE  = 0;
   localparam int FLG_PER   = 1;
   localparam int FLG_CH1   = 2;
   localparam int FLG_SYNC  = 3;
   localparam int FLG_TXE   = 4;
   localparam int FLG_RXF   = 5;
   localparam int FLG_CONV  = 6;
   localparam int FLG_PAR   = 7;
   // Writable flag bits: all but the two live serial bits
   localparam logic [7:0] FLAG_WMASK = 8'hcf;
   // Channel control fields
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_DLO_LSB  = 4;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   typedef enum logic [3:0]
   {
      MODE_OFF    = 4'h0,
      MODE_CAP_F  = 4'h4,
      MODE_CAP_R  = 4'h5,
      MODE_CAP_R4 = 4'h6,
      MODE_CAP_R16= 4'h7,
      MODE_CMP_HI = 4'h8,
      MODE_CMP_LO = 4'h9,
      MODE_CMP_SW = 4'ha,
      MODE_CMP_SE = 4'hb
   } mode_type;
   localparam logic [1:0] PWM_TOP = 2'h3;
   localparam logic [3:0] PRESC_4  = 4'h3;
   localparam logic [3:0] PRESC_16 = 4'hf;
   // Peripheral event inputs
   typedef struct packed
   {
      logic wide_ovf;
      logic period_match;
      logic sync_serial;
      logic tx_empty;
      logic rx_full;
      logic conv_done;
      logic par_access;
   } events_type;
   // Per-channel state
   typedef struct packed
   {
      logic [7:0]  ctrl;
      logic [7:0]  duty_hi;
      logic [15:0] cmp;
      logic [15:0] cap;
      logic [3:0]  presc;
      logic        pin_d;
      logic        out;
      logic [9:0]  duty_latch;
   } chan_type;
endpackage

// file: verif/ccp_far_side.sv
// Purpose: Capture pin driver standing on the far side of channel one
// Assumes: One core clock; the pin idles low between requests
// Notes:   Each request gives one rising and one falling edge
`timescale 1ns/1ns
`default_nettype none
module ccp_far_side
(
   input  wire logic clk,  // Core clock
   input  wire logic rstn, // Reset, active low
   input  wire logic go,   // One-cycle request for a pin pulse
   output var  logic pin   // Capture pin level
);
   logic [2:0] phase_r;
   // Two high cycles then two low ones, so each edge stays apart from the next
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         phase_r <= 3'h0;
      else if (go)
         phase_r <= 3'h4;
      else if (phase_r != 3'h0)
         phase_r <= phase_r - 3'h1;
   end
   // Pin level follows the phase
   always_comb
   begin
      pin = (phase_r >= 3'h3);
   end
endmodule
`default_nettype wire

// file: verif/test_ccp_core.sv
// Purpose: Self-checking bench of the capture/compare/PWM block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Bench drives the timers directly and holds them still around a capture
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module test_ccp_core;
   logic                clk, rstn, wr, rd, go, pin0, tmr_rst, conv, irq;
   logic [7:0]          addr, wdata, rdata, narrow;
   logic [15:0]         wide;
   logic [1:0]          fine, outs;
   ccp_pkg::events_type ev;
   int                  fail_count, compares, n_tr, n_cv, n;
   logic [6:0]          masks [5] = '{7'h40, 7'h20, 7'h10, 7'h02, 7'h01};
   logic [7:0]          flags [5] = '{8'h01, 8'h02, 8'h08, 8'h40, 8'h80};
   ccp_core dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .WIDE_TIMER(wide), .NARROW_TIMER(narrow), .NARROW_FINE(fine),
      .EVENTS(ev), .CH_PIN({1'b0, pin0}), .CH_OUT(outs), .TIMER_RESET(tmr_rst),
      .CONV_START(conv), .IRQ(irq));
   ccp_far_side far (.clk(clk), .rstn(rstn), .go(go), .pin(pin0));
   // Clock at 20 MHz
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Count special-event pulses; a pulse lasts one cycle, so count every edge
   always @(posedge clk)
   begin
      if (tmr_rst === 1'b1) n_tr++;
      if (conv === 1'b1) n_cv++;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // One write cycle, then a quiet cycle so the strobe is never driven twice at once
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(1);
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] ex, input string nm);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      tick(1);
      `CHK(nm, ex, rdata)
   endtask
   task automatic pulse(input logic [6:0] m);
      ev <= m;
      tick(1);
      ev <= 7'h00;
      tick(2);
   endtask
   task automatic pin_edge();
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(6);
   endtask
   // Run one compare match on channel one, then move the timer away again
   task automatic match(input logic [7:0] mode, input logic ex_out, input logic [7:0] ex_f);
      wr_reg(ccp_pkg::ADDR_CTRL1, mode);
      wide <= 16'h1234;
      tick(3);
      wide <= 16'h0000;
      tick(1);
      `CHK("channel out", ex_out, outs[0])
      expect_reg(ccp_pkg::ADDR_FLAGS, ex_f, "match flag");
      wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
   initial
   begin
      #(20000 * 50);
      fail_count++;
      wrap_up();
   end
   initial
   begin
      {wr, rd, go, addr, wdata, wide, narrow, fine} = '0;
      ev = 7'h00;
      rstn = 1'b0;
      {fail_count, compares, n_tr, n_cv} = '0;
      tick(2);
      rstn <= 1'b1;
      tick(1);
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h00, "flags reset");
      expect_reg(ccp_pkg::ADDR_ENABLES, 8'h00, "enables reset");
      wr_reg(8'h01, 8'hff);
      expect_reg(8'h01, 8'h00, "unmapped");
      $display("Test reset done");
      // Sticky event flags with every enable off
      for (int i = 0; i < 5; i++)
      begin
         pulse(masks[i]);
         tick(3);
         expect_reg(ccp_pkg::ADDR_FLAGS, flags[i], "event flag");
         wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
         expect_reg(ccp_pkg::ADDR_FLAGS, 8'h00, "flag cleared");
      end
      ev <= 7'h08;
      tick(2);
      wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h10, "tx empty live");
      ev <= 7'h04;
      tick(2);
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h20, "rx full live");
      ev <= 7'h00;
      tick(2);
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h00, "serial empty");
      $display("Test flags done");
      // Interrupt raised, masked, unmasked and cleared
      wr_reg(ccp_pkg::ADDR_ENABLES, 8'h01);
      pulse(7'h40);
      `CHK("irq raised", 1'b1, irq)
      wr_reg(ccp_pkg::ADDR_ENABLES, 8'h00);
      tick(1);
      `CHK("irq masked", 1'b0, irq)
      wr_reg(ccp_pkg::ADDR_ENABLES, 8'h01);
      tick(1);
      `CHK("irq unmasked", 1'b1, irq)
      wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
      tick(1);
      `CHK("irq cleared", 1'b0, irq)
      wr_reg(ccp_pkg::ADDR_ENABLES, 8'h00);
      $display("Test interrupt done");
      // Compare modes on channel one, then the special event on both channels
      wr_reg(ccp_pkg::ADDR_CMP1_LO, 8'h34);
      wr_reg(ccp_pkg::ADDR_CMP1_HI, 8'h12);
      match(8'h08, 1'b1, 8'h04);
      match(8'h09, 1'b0, 8'h04);
      match(8'h08, 1'b1, 8'h04);
      match(8'h0a, 1'b1, 8'h04);
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h00);
      tick(1);
      `CHK("disabled out", 1'b0, outs[0])
      match(8'h0b, 1'b0, 8'h04);
      `CHK("timer reset", 1'b1, n_tr != 0)
      `CHK("no convert on one", 1'b1, n_cv == 0)
      wr_reg(ccp_pkg::ADDR_CMP2_LO, 8'h34);
      wr_reg(ccp_pkg::ADDR_CMP2_HI, 8'h12);
      wr_reg(ccp_pkg::ADDR_CTRL2, 8'h0b);
      // The special event resets the timer, so the match stands for one cycle only
      wide <= 16'h1234;
      tick(1);
      wide <= 16'h0000;
      tick(2);
      `CHK("convert on two", 1'b1, n_cv != 0)
      wr_reg(ccp_pkg::ADDR_CTRL2, 8'h00);
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h00);
      $display("Test compare done");
      // Capture on each edge choice, the timer held still meanwhile
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h05);
      wide <= 16'hbeef;
      pin_edge();
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h04, "capture flag");
      expect_reg(ccp_pkg::ADDR_CAP1_LO, 8'hef, "capture low");
      expect_reg(ccp_pkg::ADDR_CAP1_HI, 8'hbe, "capture high");
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h04);
      wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
      wide <= 16'h5a5a;
      pin_edge();
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h04, "falling flag");
      expect_reg(ccp_pkg::ADDR_CAP1_LO, 8'h5a, "falling value");
      for (int m = 6; m < 8; m++)
      begin
         n = (m == 6) ? 4 : 16;
         wr_reg(ccp_pkg::ADDR_CTRL1, 8'(m));
         wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
         repeat (n - 1) pin_edge();
         expect_reg(ccp_pkg::ADDR_FLAGS, 8'h00, "prescale early");
         pin_edge();
         expect_reg(ccp_pkg::ADDR_FLAGS, 8'h04, "prescale edge");
      end
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h00);
      wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
      $display("Test capture done");
      // PWM with a ten-bit duty of eight, then of eleven
      wr_reg(ccp_pkg::ADDR_DUTY1, 8'h02);
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h0c);
      wide <= 16'h1234;
      tick(3);
      `CHK("pwm start", 1'b1, outs[0])
      {narrow, fine} <= 10'h007;
      tick(3);
      `CHK("pwm below duty", 1'b1, outs[0])
      {narrow, fine} <= 10'h008;
      tick(3);
      `CHK("pwm at duty", 1'b0, outs[0])
      expect_reg(ccp_pkg::ADDR_FLAGS, 8'h00, "pwm no flag");
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h3c);
      {narrow, fine} <= 10'h000;
      tick(3);
      {narrow, fine} <= 10'h00a;
      tick(3);
      `CHK("pwm low bits", 1'b1, outs[0])
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'hff);
      expect_reg(ccp_pkg::ADDR_CTRL1, 8'h3f, "ctrl upper bits");
      wr_reg(ccp_pkg::ADDR_CTRL1, 8'h00);
      tick(2);
      `CHK("pwm disabled", 1'b0, outs[0])
      $display("Test pwm done");
      wrap_up();
   end
endmodule
`default_nettype wire
